// ### hw/tes_top.v
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tes_regs.vh"

module tes_top (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire        i_ce,
	input  wire [5:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output wire [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	input  wire        i_iso_input_a,
	input  wire        i_iso_input_b,
	input  wire        i_packet_fire,
	output wire        o_exposure_active,
	output wire        o_frame_start,
	output wire        o_trigger_wait
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_DELAY  = 3'h1;
	localparam [2:0] ST_EXPOSE = 3'h2;
	localparam [2:0] ST_LEVEL  = 3'h3;
	localparam [2:0] ST_GAP    = 3'h4;

	localparam [31:0] HALF_FULL = `TES_HALF_PER_CLK;
	localparam [29:0] HALF_STEP = HALF_FULL[29:0];
	localparam [39:0] FRAME_TGT = `TES_FRAME_TARGET;

	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer      k;
		begin
			be_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					be_merge[8*k +: 8] = new_v[8*k +: 8];
				end
			end
		end
	endfunction

	function [31:0] clamp32;
		input [31:0] v;
		input [31:0] lo;
		input [31:0] hi;
		begin
			if (v < lo) begin
				clamp32 = lo;
			end else if (v > hi) begin
				clamp32 = hi;
			end else begin
				clamp32 = v;
			end
		end
	endfunction

	// register index of a bus address, 0 where nothing is mapped
	function [3:0] reg_idx;
		input [5:0] a;
		begin
			if (a == `TES_OFS_SYNC) begin
				reg_idx = 4'h1;
			end else if (a == `TES_OFS_SWFIRE) begin
				reg_idx = 4'h2;
			end else if (a == `TES_OFS_ORIGIN) begin
				reg_idx = 4'h3;
			end else if (a == `TES_OFS_POLARITY) begin
				reg_idx = 4'h4;
			end else if (a == `TES_OFS_LAG) begin
				reg_idx = 4'h5;
			end else if (a == `TES_OFS_SEQUENCE) begin
				reg_idx = 4'h6;
			end else if (a == `TES_OFS_BURST) begin
				reg_idx = 4'h7;
			end else if (a == `TES_OFS_DURATION) begin
				reg_idx = 4'h8;
			end else if (a == `TES_OFS_INTCTRL) begin
				reg_idx = 4'h9;
			end else if (a == `TES_OFS_RATE) begin
				reg_idx = 4'hA;
			end else if (a == `TES_OFS_STATUS) begin
				reg_idx = 4'hB;
			end else begin
				reg_idx = 4'h0;
			end
		end
	endfunction

	// true for the states in which the sensor integrates
	function is_expo;
		input [2:0] s;
		begin
			is_expo = (s == ST_EXPOSE) | (s == ST_LEVEL);
		end
	endfunction

	reg         sync_q;
	reg  [6:0]  origin_q;
	reg         polarity_q;
	reg  [24:0] lag_q;
	reg  [2:0]  sequence_q;
	reg  [7:0]  burst_q;
	reg  [27:0] duration_q;
	reg         intctrl_q;
	reg  [31:0] rate_q;
	reg         ack_q;
	reg  [31:0] rdata_q;
	reg         sw_fire_q;

	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [29:0] tmr_q;
	reg  [29:0] tmr_d;
	reg  [39:0] frm_q;
	reg  [39:0] frm_d;
	reg  [7:0]  left_q;
	reg  [7:0]  left_d;
	reg         pin_a_q;
	reg         pin_b_q;
	reg         exp_act_q;
	reg         fstart_q;
	reg         twait_q;

	wire        req     = i_avs_read | i_avs_write;
	wire        wr_go   = i_avs_write & ack_q;
	wire [31:0] wdat_f  = i_avs_writedata;
	wire [31:0] cur_w;
	reg  [31:0] rd_mux;

	assign o_avs_waitrequest = req & ~ack_q;
	assign o_avs_readdata    = rdata_q;

	// current value of the addressed register, base of a byte-lane merge
	assign cur_w = rd_mux;

	always @* begin
		rd_mux = 32'h00000000;
		if (i_avs_address == `TES_OFS_SYNC) begin
			rd_mux = {31'h00000000, sync_q};
		end else if (i_avs_address == `TES_OFS_ORIGIN) begin
			rd_mux = {25'h0000000, origin_q};
		end else if (i_avs_address == `TES_OFS_POLARITY) begin
			rd_mux = {31'h00000000, polarity_q};
		end else if (i_avs_address == `TES_OFS_LAG) begin
			rd_mux = {7'h00, lag_q};
		end else if (i_avs_address == `TES_OFS_SEQUENCE) begin
			rd_mux = {29'h00000000, sequence_q};
		end else if (i_avs_address == `TES_OFS_BURST) begin
			rd_mux = {24'h000000, burst_q};
		end else if (i_avs_address == `TES_OFS_DURATION) begin
			rd_mux = {4'h0, duration_q};
		end else if (i_avs_address == `TES_OFS_INTCTRL) begin
			rd_mux = {31'h00000000, intctrl_q};
		end else if (i_avs_address == `TES_OFS_RATE) begin
			rd_mux = rate_q;
		end else if (i_avs_address == `TES_OFS_STATUS) begin
			rd_mux = {16'h0000, left_q, 1'b0, state_q,
				2'h0, exp_act_q, (state_q != ST_IDLE)};
		end
	end

	wire [31:0] merged = be_merge(cur_w, wdat_f, i_avs_byteenable);

	// range limits applied before a value is stored
	wire [31:0] lag_clamp = clamp32(merged, 32'h00000000,
		{7'h00, `TES_LAG_MAX});
	wire [31:0] dur_clamp = clamp32(merged, {4'h0, `TES_DUR_MIN},
		{4'h0, `TES_DUR_MAX});
	// unmapped reads return zero, the fire command is write only
	wire        acc_map   = (reg_idx(i_avs_address) != 4'h0);
	wire        acc_fire  = (reg_idx(i_avs_address) == 4'h2);

	// one wait state per access; write lands and read data stands on the
	// edge where waitrequest is seen low
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_q      <= 1'b0;
			rdata_q    <= 32'h00000000;
			sw_fire_q  <= 1'b0;
			sync_q     <= `TES_RST_SYNC;
			origin_q   <= `TES_RST_ORIGIN;
			polarity_q <= `TES_RST_POLARITY;
			lag_q      <= `TES_RST_LAG;
			sequence_q <= `TES_RST_SEQUENCE;
			burst_q    <= `TES_RST_BURST;
			duration_q <= `TES_RST_DURATION;
			intctrl_q  <= `TES_RST_INTCTRL;
			rate_q     <= `TES_RST_RATE;
		end else if (i_ce) begin
			ack_q     <= req & ~ack_q;
			sw_fire_q <= 1'b0;
			if (i_avs_read & ~ack_q) begin
				rdata_q <= acc_map ? rd_mux : 32'h00000000;
			end
			if (wr_go) begin
				if (i_avs_address == `TES_OFS_SYNC) begin
					sync_q <= merged[0];
				end else if (acc_fire) begin
					sw_fire_q <= 1'b1;
				end else if (i_avs_address == `TES_OFS_ORIGIN) begin
					origin_q <= merged[6:0];
				end else if (i_avs_address == `TES_OFS_POLARITY) begin
					polarity_q <= merged[0];
				end else if (i_avs_address == `TES_OFS_LAG) begin
					lag_q <= lag_clamp[24:0];
				end else if (i_avs_address == `TES_OFS_SEQUENCE) begin
					sequence_q <= merged[2:0];
				end else if (i_avs_address == `TES_OFS_BURST) begin
					burst_q <= merged[7:0];
				end else if (i_avs_address == `TES_OFS_DURATION) begin
					duration_q <= dur_clamp[27:0];
				end else if (i_avs_address == `TES_OFS_INTCTRL) begin
					intctrl_q <= merged[0];
				end else if (i_avs_address == `TES_OFS_RATE) begin
					rate_q <= clamp32(merged, `TES_RATE_MIN,
						32'hFFFFFFFF);
				end
			end
		end
	end

	// trigger event sources
	wire sel_b    = (origin_q == `TES_ORG_PIN_B);
	wire pin_org  = (origin_q == `TES_ORG_PIN_A) | sel_b;
	wire [1:0] pin_raw  = {i_iso_input_b, i_iso_input_a};
	wire [1:0] pin_hist = {pin_b_q, pin_a_q};
	wire [1:0] pin_act;
	wire [1:0] pin_hit;
	genvar     g;

	// polarity applied per pin so one compare finds either edge
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_pin
			assign pin_act[g] = pin_raw[g] ^ polarity_q;
			assign pin_hit[g] = pin_act[g] & ~(pin_hist[g] ^ polarity_q);
		end
	endgenerate

	wire act_now  = sel_b ? pin_act[1] : pin_act[0];
	wire pin_edge = pin_org & (sel_b ? pin_hit[1] : pin_hit[0]);
	wire link_evt = (origin_q == `TES_ORG_LINK) & i_packet_fire;
	wire soft_evt = (origin_q == `TES_ORG_SOFT) & sw_fire_q;
	wire trig_evt = sync_q & (pin_edge | link_evt | soft_evt);

	// the lag and duration timer counts half raw units, a whole number per clock
	wire [29:0] tmr_nxt  = tmr_q + HALF_STEP;
	wire [39:0] frm_nxt  = frm_q + {8'h00, rate_q};
	wire        frm_done = (frm_nxt >= FRAME_TGT);
	wire        lag_done = (tmr_nxt >= {4'h0, lag_q, 1'b0});
	wire        dur_done = (tmr_nxt >= {1'b0, duration_q, 1'b0});
	wire        exp_done = intctrl_q ? dur_done : frm_done;
	wire        more     = sync_q ? (left_q != 8'h00) : 1'b1;

	always @* begin
		state_d = state_q;
		tmr_d   = tmr_q;
		frm_d   = frm_q;
		left_d  = left_q;
		case (state_q)
		ST_IDLE: begin
			tmr_d = 30'h00000000;
			frm_d = 40'h0000000000;
			if (!sync_q) begin
				state_d = ST_EXPOSE;
			end else if (trig_evt) begin
				state_d = ST_DELAY;
				left_d  = 8'h00;
				if (sequence_q == `TES_SEQ_BURST && burst_q != 8'h00) begin
					left_d = burst_q - 8'h01;
				end
			end
		end
		ST_DELAY: begin
			tmr_d = tmr_nxt;
			if (lag_done) begin
				tmr_d = 30'h00000000;
				frm_d = 40'h0000000000;
				if (sequence_q == `TES_SEQ_PULSE) begin
					state_d = ST_LEVEL;
				end else begin
					state_d = ST_EXPOSE;
				end
			end
		end
		ST_EXPOSE: begin
			tmr_d = tmr_nxt;
			frm_d = frm_nxt;
			if (exp_done) begin
				state_d = ST_GAP;
			end
		end
		ST_LEVEL: begin
			frm_d = frm_nxt;
			if (!act_now) begin
				state_d = ST_GAP;
			end
		end
		ST_GAP: begin
			// frame period is only closed after the exposure ended
			frm_d = frm_nxt;
			if (frm_done) begin
				tmr_d = 30'h00000000;
				frm_d = 40'h0000000000;
				if (more && (sync_q == 1'b0 || sequence_q == `TES_SEQ_BURST)) begin
					state_d = ST_EXPOSE;
					if (sync_q) begin
						left_d = left_q - 8'h01;
					end
				end else begin
					state_d = ST_IDLE;
				end
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q   <= ST_IDLE;
			tmr_q     <= 30'h00000000;
			frm_q     <= 40'h0000000000;
			left_q    <= 8'h00;
			pin_a_q   <= 1'b0;
			pin_b_q   <= 1'b0;
			exp_act_q <= 1'b0;
			fstart_q  <= 1'b0;
			twait_q   <= 1'b0;
		end else if (i_ce) begin
			state_q   <= state_d;
			tmr_q     <= tmr_d;
			frm_q     <= frm_d;
			left_q    <= left_d;
			pin_a_q   <= i_iso_input_a;
			pin_b_q   <= i_iso_input_b;
			exp_act_q <= is_expo(state_d);
			fstart_q  <= is_expo(state_d) & (state_d != state_q);
			twait_q   <= (state_d == ST_IDLE) & sync_q;
		end
	end

	assign o_exposure_active = exp_act_q;
	assign o_frame_start     = fstart_q;
	assign o_trigger_wait    = twait_q;

endmodule // tes_top

// ### hw/tes_regs.vh
// Functional notes
// - capture_sync_select: 0 free-run (default), 1 triggered operation.
// - capture_sequence_select: 0 edge, 1 pulse width, 6 burst; default 0.
// - edge sequence: one trigger starts one exposure of integration_duration length.
// - pulse-width sequence: exposure lasts while the trigger pin stays active.
// - burst sequence: one trigger gives burst_frame_total frames, range 0 to 255; a value of 0 gives one frame.
// - burst_frame_total is ignored outside the burst sequence.
// - fire_origin_select: 0 input a, 1 input b, 2 link, 64 software.
// - trigger packets arriving over the camera link are accepted as triggers.
// - pin triggers act on an edge whose polarity is programmable.
// - fire_to_expose_lag delays exposure, 0 to 25000000 units of 1/125 us.
// - the lag applies to pin and software triggers alike.
// - a software fire write makes one trigger; its latency is not fixed.
// - integration_duration ranges 1250 to 200000000, default 1875000, 1/125 us units.
// - integration control picks rate-derived or manual exposure length.
// - exposure longer than the frame period stretches the frame period.
`ifndef TES_REGS_VH
`define TES_REGS_VH

`define TES_OFS_SYNC       6'h00
`define TES_OFS_SWFIRE     6'h04
`define TES_OFS_ORIGIN     6'h08
`define TES_OFS_POLARITY   6'h0C
`define TES_OFS_LAG        6'h10
`define TES_OFS_SEQUENCE   6'h14
`define TES_OFS_BURST      6'h18
`define TES_OFS_DURATION   6'h1C
`define TES_OFS_INTCTRL    6'h20
`define TES_OFS_RATE       6'h24
`define TES_OFS_STATUS     6'h28

`define TES_RST_SYNC       1'h0
`define TES_RST_ORIGIN     7'h00
`define TES_RST_POLARITY   1'h0
`define TES_RST_LAG        25'h0000000
`define TES_RST_SEQUENCE   3'h0
`define TES_RST_BURST      8'h00
`define TES_RST_DURATION   28'h01C9C38
`define TES_RST_INTCTRL    1'h0
`define TES_RST_RATE       32'h00408724

`define TES_SEQ_EDGE       3'h0
`define TES_SEQ_PULSE      3'h1
`define TES_SEQ_BURST      3'h6
`define TES_ORG_PIN_A      7'h00
`define TES_ORG_PIN_B      7'h01
`define TES_ORG_LINK       7'h02
`define TES_ORG_SOFT       7'h40

`define TES_LAG_MAX        25'h17D7840
`define TES_DUR_MIN        28'h00004E2
`define TES_DUR_MAX        28'hBEBC200
`define TES_RATE_MIN       32'h00000FFF

`define TES_CLK_PERIOD_NS  100
`define TES_RAW_PER_US     125
`define TES_RATE_SCALE     65536
`define TES_HALF_PER_CLK   ((2 * `TES_RAW_PER_US * `TES_CLK_PERIOD_NS) / 1000)
`define TES_FRAME_TARGET   (40'd1000000000 / 40'd`TES_CLK_PERIOD_NS * 40'd`TES_RATE_SCALE)

`endif

// ### tb/tes_chk_sva.sv
`timescale 1ns/1ps
module tes_chk (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic [5:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_exposure_active,
	input wire logic        o_frame_start,
	input wire logic        o_trigger_wait
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire req = i_avs_read | i_avs_write;
	property p_idle_busy;
		o_trigger_wait |-> !o_exposure_active;
	endproperty
	a_idle_busy: assert property (p_idle_busy) else $error("ready while busy");
	property p_fs_in_exp;
		o_frame_start |-> o_exposure_active;
	endproperty
	a_fs_in_exp: assert property (p_fs_in_exp) else $error("start outside");
	property p_exp_rise;
		$rose(o_exposure_active) |-> o_frame_start;
	endproperty
	a_exp_rise: assert property (p_exp_rise) else $error("no frame start");
	property p_fs_pulse;
		o_frame_start |=> !o_frame_start;
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("long start");
	property p_ack;
		req && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("no bus answer");
	property p_no_req;
		!req |-> !o_avs_waitrequest;
	endproperty
	a_no_req: assert property (p_no_req) else $error("stray wait");
	property p_unmapped;
		i_avs_read && !o_avs_waitrequest && i_avs_address == 6'h3C
			|-> o_avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_free_run;
		$rose(i_reset_n) |=> o_frame_start ##1 o_exposure_active;
	endproperty
	a_free_run: assert property (p_free_run) else $error("no free run");
endmodule // tes_chk

bind tes_top tes_chk tes_chk_i (.i_clk, .i_reset_n, .i_avs_address,
	.i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.o_exposure_active, .o_frame_start, .o_trigger_wait);

// ### tb/tes_src.sv
`timescale 1ns/1ps
module tes_src (
	input  wire logic i_clk,
	output logic      o_pin_a,
	output logic      o_pin_b,
	output logic      o_pkt
);
	initial {o_pin_a, o_pin_b, o_pkt} = 3'h0;
	// park the line idle first so only the wanted edge is seen
	task automatic fire(input int ch, input logic pol, input int w);
		@(posedge i_clk);
		set(ch, pol);
		@(posedge i_clk);
		set(ch, !pol);
		repeat (w) @(posedge i_clk);
		set(ch, pol);
	endtask
	task automatic set(input int ch, input logic v);
		if (ch == 0) o_pin_a <= v;
		else if (ch == 1) o_pin_b <= v;
		else o_pkt <= v;
	endtask
endmodule // tes_src

// ### tb/trigger_exposure_sequencer_test.sv
`timescale 1ns/1ps
module trigger_exposure_sequencer_test;
	logic        clk, rst_n, rd, we, pol;
	logic [5:0]  adr;
	logic [31:0] wd, rdat;
	wire  [31:0] rdata;
	wire         wq, pa, pb, pk, ex, fs, tw;
	int          err_count, check_count, cyc, t0, tfs, nfs, nexp, b, lag, w;
	int          ofs[8] = '{0, 4, 8, 'h10, 'h14, 'h18, 'h1C, 'h3C};
	int          rv[8] = '{0, 0, 0, 0, 0, 0, 'h1C9C38, 0};
	int          org[2] = '{0, 64};
	tes_top tes_top_i (.i_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wq),
		.i_iso_input_a(pa), .i_iso_input_b(pb), .i_packet_fire(pk),
		.o_exposure_active(ex), .o_frame_start(fs), .o_trigger_wait(tw));
	tes_src tes_src_i (.i_clk(clk), .o_pin_a(pa), .o_pin_b(pb), .o_pkt(pk));
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	function automatic int cdiv(int n, int d);
		return (n + d - 1) / d;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w_, input logic [5:0] a, input int d);
		@(posedge clk);
		rd <= !w_;
		we <= w_;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wq !== 1'b0);
		rdat = rdata;
		rd <= 1'b0;
		we <= 1'b0;
	endtask
	// n triggers back to back, then wait for the sequencer to be ready
	task automatic shot(input int o, input int w_, input int n);
		while (tw !== 1'b1) @(negedge clk);
		@(posedge clk);
		{nfs, nexp, tfs} = 96'h0;
		t0 = cyc;
		repeat (n) begin
			if (o == 64) bus(1'b1, 6'h04, 1);
			else tes_src_i.fire(o, pol, w_);
		end
		repeat (4) @(posedge clk);
		do @(negedge clk); while (tw !== 1'b1);
	endtask
	task wrap_up;
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (fs === 1'b1 && nfs == 0) tfs = cyc;
		nfs += (fs === 1'b1);
		nexp += (ex === 1'b1);
		if (cyc == 60000) begin
			$display("ERROR %0t timeout", $time);
			err_count++;
			wrap_up;
		end
	end
	initial begin
		{rd, we, adr, wd, rst_n, pol} = '0;
		void'($urandom(32'h07231a45));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ofs[i][5:0], 0);
			chk(rdat, rv[i]);
		end
		bus(1'b1, 6'h3C, -1);
		bus(1'b0, 6'h3C, 0);
		chk(rdat, 0);
		bus(1'b1, 6'h10, 30000000);
		bus(1'b0, 6'h10, 0);
		chk(rdat, 25000000);
		bus(1'b1, 6'h24, -1);
		bus(1'b1, 6'h20, 1);
		bus(1'b1, 6'h1C, 5);
		bus(1'b0, 6'h1C, 0);
		chk(rdat, 1250);
		bus(1'b1, 6'h18, 3);
		bus(1'b1, 6'h00, 1);
		lag = $urandom_range(13, 400);
		foreach (org[k]) begin
			bus(1'b1, 6'h08, org[k]);
			bus(1'b1, 6'h10, 0);
			shot(org[k], 3, 2);
			chk(nfs, 1);
			chk(nexp, cdiv(2 * 1250, 25));
			b = tfs - t0;
			bus(1'b1, 6'h10, lag);
			shot(org[k], 3, 1);
			chk(tfs - t0 - b, cdiv(2 * lag, 25) - 1);
		end
		bus(1'b1, 6'h10, 0);
		bus(1'b1, 6'h14, 6);
		shot(64, 0, 1);
		chk(nexp, 3 * 100);
		chk(nfs, 3);
		bus(1'b1, 6'h18, 0);
		shot(64, 0, 1);
		chk(nfs, 1);
		bus(1'b1, 6'h0C, 1);
		pol = 1'b1;
		bus(1'b1, 6'h14, 0);
		bus(1'b1, 6'h08, 1);
		shot(0, 3, 1);
		chk(nfs, 0);
		shot(1, 3, 1);
		chk(nfs, 1);
		bus(1'b1, 6'h14, 1);
		w = $urandom_range(20, 59);
		shot(1, w, 1);
		b = nexp;
		shot(1, w + 25, 1);
		chk(nexp - b, 25);
		bus(1'b1, 6'h14, 0);
		bus(1'b1, 6'h08, 2);
		pol = 1'b0;
		shot(2, 1, 1);
		chk(nfs, 1);
		bus(1'b1, 6'h00, 0);
		@(posedge clk);
		nfs = 0;
		repeat (400) @(posedge clk);
		chk(nfs > 1, 1);
		wrap_up;
	end
endmodule // trigger_exposure_sequencer_test
